// File: include/vector_engine_trigger_pkg.sv
// constants for the vector engine trigger register slice
package vector_engine_trigger_pkg;
    localparam logic [7:0]  TRG_CORR_OFS   = 8'h00;
    localparam logic [7:0]  CMP_A_OFS      = 8'h04;
    localparam logic [7:0]  CMP_B_OFS      = 8'h08;
    localparam logic [7:0]  TRG_SEL_OFS    = 8'h0c;
    localparam logic [7:0]  EMG_RET_OFS    = 8'h10;
    localparam logic [15:0] TRG_CORR_RST   = 16'h0000;
    localparam logic [15:0] CMP_RST        = 16'h0000;
    localparam logic [2:0]  TRG_SEL_RST    = 3'h0;
    localparam int          EMG_CMD_BIT    = 0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // pwm trigger modes that make the compare values meaningful
    localparam logic [2:0]  TRGMD_DOWN     = 3'h1;
    localparam logic [2:0]  TRGMD_UP       = 3'h2;
    localparam logic [2:0]  TRGMD_UPDOWN   = 3'h3;
    localparam logic [1:0]  SHIFT_OFF      = 2'h0;
    localparam logic [1:0]  SHIFT_MODE1    = 2'h1;
endpackage

// File: hw/vector_engine_trigger_regs.sv
// axi4-lite register slice feeding the pwm unit trigger parameters
`timescale 1ns/1ps
`default_nettype none
module vector_engine_trigger_regs
    import vector_engine_trigger_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [2:0]  pwm_trigger_mode_i,
    input  wire logic        trigger_output_mode_bit_i,
    input  wire logic [1:0]  pwm_shift_mode_i,
    input  wire logic        trigger_task_run_i,
    input  wire logic        output_task_run_i,
    input  wire logic        emergency_return_mode_i,
    output logic [15:0]      trigger_correction_value_o,
    output logic             trigger_correction_valid_o,
    output logic [15:0]      adc_compare_first_o,
    output logic             adc_compare_first_valid_o,
    output logic [15:0]      adc_compare_second_o,
    output logic             adc_compare_second_valid_o,
    output logic [2:0]       trigger_number_select_o,
    output logic             trigger_number_valid_o,
    output logic             emergency_return_cmd_o
);
    logic [15:0] corr_reg;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    logic [2:0]  sel_reg;
    logic        emg_reg;
    logic [7:0]  aw_addr_reg;
    logic        aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_held_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        wr_fire;
    logic        wr_hit;
    logic        shift_ok;
    logic        mode_ok;
    logic [15:0] corr_next;
    logic [15:0] cmp_a_next;
    logic [15:0] cmp_b_next;
    logic [2:0]  sel_next;
    logic [31:0] rd_next;
    logic        rd_hit;

    // write address and data are taken independently, then joined
    assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // upper address bits must be zero too, so aliases answer slverr
    always_comb begin
        unique case (aw_addr_reg)
            TRG_CORR_OFS, CMP_A_OFS, CMP_B_OFS,
            TRG_SEL_OFS, EMG_RET_OFS: wr_hit = 1'b1;
            default:                  wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o  = bresp_reg;

    // byte-lane merge; bits 31..16 are dropped here
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old_v[15:8],
                   s[0] ? d[7:0]  : old_v[7:0]};
    endfunction

    always_comb begin
        corr_next  = merge16(corr_reg, w_data_reg, w_strb_reg);
        cmp_a_next = merge16(cmp_a_reg, w_data_reg, w_strb_reg);
        cmp_b_next = merge16(cmp_b_reg, w_data_reg, w_strb_reg);
        sel_next   = w_strb_reg[0] ? w_data_reg[2:0] : sel_reg;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            corr_reg <= TRG_CORR_RST;
        end else if (wr_fire && aw_addr_reg == TRG_CORR_OFS) begin
            corr_reg <= corr_next;
        end
    end

    // out-of-range compare values are stored as written; software owns it
    // clamping here would hide a software fault instead of exposing it
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cmp_a_reg <= CMP_RST;
        end else if (wr_fire && aw_addr_reg == CMP_A_OFS) begin
            cmp_a_reg <= cmp_a_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cmp_b_reg <= CMP_RST;
        end else if (wr_fire && aw_addr_reg == CMP_B_OFS) begin
            cmp_b_reg <= cmp_b_next;
        end
    end

    // codes 6 and 7 are stored untouched and handed to the pwm unit like any other code
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sel_reg <= TRG_SEL_RST;
        end else if (wr_fire && aw_addr_reg == TRG_SEL_OFS) begin
            sel_reg <= sel_next;
        end
    end

    // one-cycle command pulse; hardware set from output tasks joins it
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            emg_reg <= 1'b0;
        end else begin
            emg_reg <= (wr_fire && aw_addr_reg == EMG_RET_OFS &&
                        w_strb_reg[0] && w_data_reg[EMG_CMD_BIT])
                    || (output_task_run_i && emergency_return_mode_i);
        end
    end
    assign emergency_return_cmd_o = emg_reg;

    assign shift_ok = pwm_shift_mode_i == SHIFT_OFF ||
                      pwm_shift_mode_i == SHIFT_MODE1;
    assign mode_ok  = pwm_trigger_mode_i == TRGMD_DOWN ||
                      pwm_trigger_mode_i == TRGMD_UP ||
                      pwm_trigger_mode_i == TRGMD_UPDOWN;

    // values are latched at each trigger task run and stay until the next
    // a write between runs is seen only at the next run, never mid-period
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trigger_correction_value_o <= TRG_CORR_RST;
        end else if (trigger_task_run_i) begin
            trigger_correction_value_o <= corr_reg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            adc_compare_first_o <= CMP_RST;
        end else if (trigger_task_run_i) begin
            adc_compare_first_o <= cmp_a_reg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            adc_compare_second_o <= CMP_RST;
        end else if (trigger_task_run_i) begin
            adc_compare_second_o <= cmp_b_reg;
        end
    end

    // the selector is handed over on every run, even when not effective
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trigger_number_select_o <= TRG_SEL_RST;
        end else if (trigger_task_run_i) begin
            trigger_number_select_o <= sel_reg;
        end
    end

    // valid flags follow the pwm mode inputs with one cycle of lag
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trigger_correction_valid_o <= 1'b0;
        end else begin
            trigger_correction_valid_o <= shift_ok;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            adc_compare_first_valid_o <= 1'b0;
        end else begin
            adc_compare_first_valid_o <= shift_ok && mode_ok;
        end
    end

    // trigger-select output leaves no use for the second compare value
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            adc_compare_second_valid_o <= 1'b0;
        end else begin
            adc_compare_second_valid_o <= shift_ok && mode_ok &&
                                          !trigger_output_mode_bit_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            trigger_number_valid_o <= 1'b0;
        end else begin
            trigger_number_valid_o <= trigger_output_mode_bit_i;
        end
    end

    // read side
    // address decoded straight off the bus; it is captured with the data
    assign s_axi_arready_o = !rvalid_reg;

    always_comb begin
        rd_next = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr_i)
            TRG_CORR_OFS: rd_next = {16'h0000, corr_reg};
            CMP_A_OFS:    rd_next = {16'h0000, cmp_a_reg};
            CMP_B_OFS:    rd_next = {16'h0000, cmp_b_reg};
            TRG_SEL_OFS:  rd_next = {29'h0000_0000, sel_reg};
            EMG_RET_OFS:  rd_next = 32'h0000_0000;
            default:      rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_next;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o  = rresp_reg;
    assign s_axi_rdata_o  = rdata_reg;
endmodule
`default_nettype wire

// File: tb/pwm_unit_model.sv
// pwm unit model issuing task pulses to the register slice
`timescale 1ns/1ps
`default_nettype none
module pwm_unit_model (
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic go_trig_i,
    input  wire logic go_out_i,
    output logic      trigger_task_run_o,
    output logic      output_task_run_o
);
    // tasks never run on two cycles in a row, so pulses are one cycle
    always_ff @(posedge clk_sys_i) begin
        trigger_task_run_o <= rst_b_i && go_trig_i && !trigger_task_run_o;
        output_task_run_o  <= rst_b_i && go_out_i && !output_task_run_o;
    end
endmodule
`default_nettype wire

// File: tb/vector_engine_trigger_regs_monitor.sv
// port checks for the trigger register slice
`timescale 1ns/1ps
`default_nettype none
module vector_engine_trigger_regs_monitor
    import vector_engine_trigger_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic [2:0]  pwm_trigger_mode_i,
    input wire logic        trigger_output_mode_bit_i,
    input wire logic [1:0]  pwm_shift_mode_i,
    input wire logic        trigger_task_run_i,
    input wire logic        output_task_run_i,
    input wire logic        emergency_return_mode_i,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        trigger_correction_valid_o,
    input wire logic        adc_compare_first_valid_o,
    input wire logic        adc_compare_second_valid_o,
    input wire logic [2:0]  trigger_number_select_o,
    input wire logic        trigger_number_valid_o,
    input wire logic        emergency_return_cmd_o
);
    logic sh_ok;
    logic md_ok;
    assign sh_ok = pwm_shift_mode_i inside {SHIFT_OFF, SHIFT_MODE1};
    assign md_ok = pwm_trigger_mode_i inside {TRGMD_DOWN, TRGMD_UP,
                                              TRGMD_UPDOWN};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    chk_corr_gate: assert property (
        $past(rst_b_i) |-> trigger_correction_valid_o == $past(sh_ok))
        else $error("correction valid wrong");
    chk_first_gate: assert property (
        $past(rst_b_i) |-> adc_compare_first_valid_o == $past(sh_ok && md_ok))
        else $error("first compare valid wrong");
    chk_second_gate: assert property (
        $past(rst_b_i) |-> adc_compare_second_valid_o ==
        $past(sh_ok && md_ok && !trigger_output_mode_bit_i))
        else $error("second compare valid wrong");
    chk_sel_gate: assert property (
        $past(rst_b_i) |-> trigger_number_valid_o == $past(trigger_output_mode_bit_i))
        else $error("selector valid wrong");
    chk_sel_hold: assert property (
        !trigger_task_run_i |=> $stable(trigger_number_select_o))
        else $error("selector changed without task");
    chk_emg_hw: assert property (
        output_task_run_i && emergency_return_mode_i |=> emergency_return_cmd_o)
        else $error("return command missing");
    chk_emg_cause: assert property (
        emergency_return_cmd_o |-> $rose(s_axi_bvalid_o) ||
        $past(output_task_run_i && emergency_return_mode_i))
        else $error("return command without cause");
    chk_emg_clear: assert property (
        emergency_return_cmd_o && !output_task_run_i |=> !emergency_return_cmd_o)
        else $error("return command held");
    chk_upper_zero: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    cover property (emergency_return_cmd_o);
    cover property (trigger_task_run_i && trigger_number_valid_o);
    cover property (trigger_task_run_i && adc_compare_second_valid_o);
endmodule
`default_nettype wire

// File: tb/vector_engine_trigger_regs_test.sv
// register slice testbench with axi4-lite master tasks
`timescale 1ns/1ps
`default_nettype none
module vector_engine_trigger_regs_test
    import vector_engine_trigger_pkg::*;
;
    logic        clk_sys_i, rst_b_i, go_trig, go_out, trigger_output_mode_bit_i;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, pwm_shift_mode_i;
    logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_bvalid_o;
    logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
    logic        s_axi_arready_o, s_axi_rvalid_o, emergency_return_mode_i;
    logic [2:0]  pwm_trigger_mode_i, trigger_number_select_o;
    logic        trigger_task_run_i, output_task_run_i, emergency_return_cmd_o;
    logic [15:0] trigger_correction_value_o, adc_compare_first_o;
    logic [15:0] adc_compare_second_o;
    logic        trigger_correction_valid_o, adc_compare_first_valid_o;
    logic        adc_compare_second_valid_o, trigger_number_valid_o;
    int          n_fail, tests_run, cyc, k;
    vector_engine_trigger_regs dut (.clk_sys_i, .rst_b_i, .s_axi_awaddr_i,
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .pwm_trigger_mode_i, .trigger_output_mode_bit_i, .pwm_shift_mode_i,
        .trigger_task_run_i, .output_task_run_i, .emergency_return_mode_i,
        .trigger_correction_value_o, .trigger_correction_valid_o,
        .adc_compare_first_o, .adc_compare_first_valid_o, .adc_compare_second_o,
        .adc_compare_second_valid_o, .trigger_number_select_o,
        .trigger_number_valid_o, .emergency_return_cmd_o);
    pwm_unit_model pwm (.clk_sys_i, .rst_b_i, .go_trig_i(go_trig),
        .go_out_i(go_out), .trigger_task_run_o(trigger_task_run_i),
        .output_task_run_o(output_task_run_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            give_verdict;
        end
    end
    // address and data are offered together and dropped as each is taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
            input logic ec);
        logic aw, w, b;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            aw = s_axi_awvalid_i && s_axi_awready_o;
            w = s_axi_wvalid_i && s_axi_wready_o;
            b = s_axi_bvalid_o;
            if (b) begin
                chk(32'(s_axi_bresp_o), 32'(er));
                chk(32'(emergency_return_cmd_o), 32'(ec));
            end
            @(posedge clk_sys_i);
            if (aw) s_axi_awvalid_i <= 1'b0;
            if (w) s_axi_wvalid_i <= 1'b0;
        end while (!b);
        s_axi_bready_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, r;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            ar = s_axi_arvalid_i && s_axi_arready_o;
            r = s_axi_rvalid_o;
            if (r) begin
                chk(s_axi_rdata_o, ed);
                chk(32'(s_axi_rresp_o), 32'(er));
            end
            @(posedge clk_sys_i);
            if (ar) s_axi_arvalid_i <= 1'b0;
        end while (!r);
        s_axi_rready_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // request through the model; results stand just after the second edge
    task fire(input logic tr, input logic ou);
        go_trig <= tr;
        go_out <= ou;
        @(posedge clk_sys_i);
        go_trig <= 1'b0;
        go_out <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    initial begin
        {rst_b_i, go_trig, go_out, s_axi_awvalid_i, s_axi_wvalid_i} = '0;
        {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        {pwm_shift_mode_i, pwm_trigger_mode_i, trigger_output_mode_bit_i} = '0;
        emergency_return_mode_i = 1'b0;
        s_axi_wstrb_i = 4'hf;
        {n_fail, tests_run, cyc} = '0;
        repeat (12) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        for (k = 0; k < 6; k++) rd(8'(k * 4), 32'h0, k == 5 ? RESP_SLVERR : RESP_OKAY);
        wr(TRG_CORR_OFS, 32'hffff_a5c3, RESP_OKAY, 1'b0);
        rd(TRG_CORR_OFS, 32'h0000_a5c3, RESP_OKAY);
        wr(8'h14, 32'h0000_1234, RESP_SLVERR, 1'b0);
        wr(EMG_RET_OFS, 32'h1, RESP_OKAY, 1'b1);
        rd(EMG_RET_OFS, 32'h0, RESP_OKAY);
        emergency_return_mode_i <= 1'b1;
        fire(1'b0, 1'b1);
        chk(32'(emergency_return_cmd_o), 32'h1);
        @(posedge clk_sys_i);
        #1 chk(32'(emergency_return_cmd_o), 32'h0);
        emergency_return_mode_i <= 1'b0;
        fire(1'b0, 1'b1);
        chk(32'(emergency_return_cmd_o), 32'h0);
        for (int s = 0; s < 3; s++) for (int m = 0; m < 5; m++) for (int t = 0; t < 2; t++) begin
            k = s * 10 + m * 2 + t;
            wr(CMP_A_OFS, 32'(k + 1), RESP_OKAY, 1'b0);
            wr(CMP_B_OFS, 32'(k + 256), RESP_OKAY, 1'b0);
            wr(TRG_SEL_OFS, 32'hfff8 | 32'(k % 6), RESP_OKAY, 1'b0);
            pwm_shift_mode_i <= 2'(s);
            pwm_trigger_mode_i <= 3'(m);
            trigger_output_mode_bit_i <= t[0];
            fire(1'b1, 1'b0);
            chk(32'(trigger_correction_valid_o), 32'(s < 2));
            chk(32'(adc_compare_first_valid_o), 32'(s < 2 && m inside {[1:3]}));
            chk(32'(adc_compare_second_valid_o), 32'(s < 2 && m inside {[1:3]} && t == 0));
            chk(32'(trigger_number_valid_o), 32'(t));
            chk(32'(trigger_number_select_o), 32'(k % 6));
            chk({adc_compare_second_o, adc_compare_first_o}, {16'(k + 256), 16'(k + 1)});
            chk(32'(trigger_correction_value_o), 32'h0000_a5c3);
        end
        give_verdict;
    end
endmodule
bind vector_engine_trigger_regs vector_engine_trigger_regs_monitor mon (
    .clk_sys_i, .rst_b_i, .pwm_trigger_mode_i, .trigger_output_mode_bit_i,
    .pwm_shift_mode_i, .trigger_task_run_i, .output_task_run_i,
    .emergency_return_mode_i, .s_axi_bvalid_o, .s_axi_rvalid_o, .s_axi_rdata_o,
    .trigger_correction_valid_o, .adc_compare_first_valid_o,
    .adc_compare_second_valid_o, .trigger_number_select_o,
    .trigger_number_valid_o, .emergency_return_cmd_o);
`default_nettype wire
